// file: include/lcd_refresh_pkg.sv
// Shared constants and carrier types of the LCD refresh controller.
package lcd_refresh_pkg;

	// Fixed raster geometry.
	localparam int unsigned LINE_PIXELS = 128;
	localparam int unsigned FRAME_LINES = 128;
	localparam int unsigned FRAME_WORDS = 512;
	localparam int unsigned WORD_BITS = 32;
	localparam int unsigned NIBBLE_BITS = 4;
	localparam int unsigned NIBBLES_PER_WORD = WORD_BITS / NIBBLE_BITS;
	localparam int unsigned NIBBLES_PER_LINE = LINE_PIXELS / NIBBLE_BITS;

	// Fetch shape on the local peripheral bus.
	localparam int unsigned BURST_WORDS = 2;
	localparam int unsigned REFRESH_FIFO_DEPTH = 3;
	localparam int unsigned LINK_BUF_DEPTH = 2;
	localparam logic [31:0] FB_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_STRIDE = 32'h0000_0004;

	// Timing: one word per 500 ns at a 16 MHz nibble rate.
	localparam int unsigned SHIFT_RATE_HZ = 16_000_000;
	localparam int unsigned WORD_PERIOD_NS = 500;
	localparam int unsigned SYS_CLK_HZ = 50_000_000;
	localparam int unsigned SYS_CYCLES_PER_WORD = (WORD_PERIOD_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

	// Field widths of the counters.
	localparam int unsigned NIB_IDX_W = $clog2(NIBBLES_PER_WORD);
	localparam int unsigned COL_IDX_W = $clog2(NIBBLES_PER_LINE);
	localparam int unsigned ROW_IDX_W = $clog2(FRAME_LINES);
	localparam int unsigned WORD_IDX_W = $clog2(FRAME_WORDS);

	// Read command presented to the bus arbiter.
	typedef struct packed {
		logic req;
		logic [31:0] addr;
		logic [1:0] burst_len;
	} lpb_cmd_t;

	// Pins toward the column and row drivers.
	typedef struct packed {
		logic [3:0] column_nibble_out;
		logic column_shift_clock;
		logic line_latch_pulse;
		logic frame_signal;
		logic row_scan_start;
		logic row_shift_clock;
	} lcd_pins_t;

endpackage

// file: rtl/bit_sync.sv
// Two-flip-flop level synchroniser.
`timescale 1ns/1ps
module bit_sync (
	// Destination clock.
	input wire logic clk_i,
	// Level from another domain.
	input wire logic d_i,
	// Synchronised level.
	output logic q_o
);
	logic meta_ff;

	// First stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		meta_ff <= d_i;
		q_o <= meta_ff;
	end
endmodule

// file: rtl/word_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 3
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Fill side.
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side.
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Occupancy.
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic push;
	logic pop;

	// Honest full and empty from the occupancy count.
	assign in_ready_o = (count_o != ($clog2(DEPTH+1))'(DEPTH));
	assign out_valid_o = (count_o != '0);
	assign out_data_o = mem[rd_ptr_ff];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Storage write.
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data_i;
		end
	end

	// Pointers wrap at the last entry, so any depth works.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
			end
		end
	end

	// Occupancy tracks pushes against pops.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count_o <= '0;
		end else if (push && !pop) begin
			count_o <= count_o + 1'b1;
		end else if (pop && !push) begin
			count_o <= count_o - 1'b1;
		end
	end
endmodule

// file: rtl/lcd_refresh_controller.sv
// Display refresh controller: bus fetch, word crossing and nibble shifter.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Raster fixed at 128 by 128 pixels; no software control of format or timing.
// - Controller masters the peripheral bus and fetches refresh data by itself.
// - Fetched words enter the refresh FIFO by block transfers on the bus.
// - Shifter sends FIFO words as 4-bit nibbles at the 16 MHz shift rate.
// - Next word is ready whenever eight nibbles have left the shifter.
// - Every frame-buffer fetch is a two-word burst read.
// - FIFO holds three words; a new burst starts once two entries are free.
// - Frame buffer is read as 512 consecutive words of 32 pixels each.
// - Most significant bit of the base word is the top-left pixel.
// - Least significant bit of the first word is pixel 32 of row one.
// - Four column data lines plus a column shift clock per nibble.
// - Drive scan start, row shift clock, line latch and frame signal.
module lcd_refresh_controller #(
	parameter logic [31:0] FB_BASE = lcd_refresh_pkg::FB_BASE_RESET
) (
	// System clock and reset.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Local peripheral bus, master side.
	output lcd_refresh_pkg::lpb_cmd_t lpb_cmd_o,
	input wire logic lpb_gnt_i,
	input wire logic lpb_rvalid_i,
	input wire logic [31:0] lpb_rdata_i,
	// Shift clock of the driver link.
	input wire logic clk_link_i,
	// Driver pins.
	output lcd_refresh_pkg::lcd_pins_t lcd_pins_o,
	// Sticky flag: the shifter had to wait for a word.
	output logic underrun_o
);
	import lcd_refresh_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// System domain: burst fetch.

	typedef enum logic [1:0] {
		FETCH_IDLE,
		FETCH_REQ,
		FETCH_DATA
	} fetch_state_t;

	fetch_state_t fetch_state_ff;
	logic [WORD_IDX_W-1:0] word_idx_ff;
	logic [1:0] beat_ff;
	logic [1:0] fifo_count;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [WORD_BITS-1:0] fifo_out_data;
	logic fifo_has_room;
	logic beat_in;

	// Two free entries are needed before a burst may start.
	assign fifo_has_room = (fifo_count <= 2'(REFRESH_FIFO_DEPTH - BURST_WORDS));
	assign beat_in = (fetch_state_ff == FETCH_DATA) && lpb_rvalid_i;

	// Fetch sequencer: request, wait for grant, collect two beats.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			fetch_state_ff <= FETCH_IDLE;
			beat_ff <= '0;
		end else begin
			unique case (fetch_state_ff)
				FETCH_IDLE: begin
					if (fifo_has_room) begin
						fetch_state_ff <= FETCH_REQ;
					end
				end
				FETCH_REQ: begin
					if (lpb_gnt_i) begin
						fetch_state_ff <= FETCH_DATA;
						beat_ff <= '0;
					end
				end
				FETCH_DATA: begin
					if (lpb_rvalid_i) begin
						beat_ff <= beat_ff + 1'b1;
						if (beat_ff == 2'(BURST_WORDS - 1)) begin
							fetch_state_ff <= FETCH_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Word index runs through the frame and wraps to the base.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			word_idx_ff <= '0;
		end else if (beat_in) begin
			word_idx_ff <= word_idx_ff + 1'b1;
		end
	end

	// Command register toward the arbiter, held until the grant.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			lpb_cmd_o <= '0;
		end else if (fetch_state_ff == FETCH_IDLE && fifo_has_room) begin
			lpb_cmd_o.req <= 1'b1;
			lpb_cmd_o.addr <= FB_BASE + {word_idx_ff, 2'b00};
			lpb_cmd_o.burst_len <= 2'(BURST_WORDS);
		end else if (fetch_state_ff == FETCH_REQ && lpb_gnt_i) begin
			lpb_cmd_o.req <= 1'b0;
		end
	end

	// Refresh FIFO filled by the burst beats.
	// Room for both beats is reserved before each request, so its ready output is not needed.
	word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(REFRESH_FIFO_DEPTH)
	) u_refresh_fifo (
		.clk_i(clk_sys_i),
		.srst_i(srst_i),
		.in_valid_i(beat_in),
		.in_ready_o(),
		.in_data_i(lpb_rdata_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data),
		.count_o(fifo_count)
	);

	////////////////////////////////////////////////////////////////////////////
	// System domain: word handshake toward the link.

	logic xfer_pend_ff;
	logic req_tgl_ff;
	logic [WORD_BITS-1:0] hold_word_ff;
	logic ack_tgl_sync;

	// One word is in flight at a time; the FIFO drains only when idle.
	assign fifo_out_ready = !xfer_pend_ff;

	// Hold register stays stable while the request toggle is pending.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			xfer_pend_ff <= 1'b0;
			req_tgl_ff <= 1'b0;
			hold_word_ff <= '0;
		end else if (!xfer_pend_ff) begin
			if (fifo_out_valid) begin
				hold_word_ff <= fifo_out_data;
				req_tgl_ff <= !req_tgl_ff;
				xfer_pend_ff <= 1'b1;
			end
		end else if (ack_tgl_sync == req_tgl_ff) begin
			xfer_pend_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Crossings.

	logic rst_link;
	logic req_tgl_sync;
	logic ack_tgl_ff;

	// Each word crosses by a toggle handshake: the held word stays put until the
	// acknowledge toggle returns, so the link side never samples a moving word.
	// The link side resets through its own synchroniser, so srst_i must stay high
	// for at least four link clock edges; a shorter reset could leave a stale
	// acknowledge toggle that releases a word the link side never took.
	bit_sync u_rst_sync (
		.clk_i(clk_link_i),
		.d_i(srst_i),
		.q_o(rst_link)
	);

	// The request toggle reaches the link clock through two flip-flops.
	bit_sync u_req_sync (
		.clk_i(clk_link_i),
		.d_i(req_tgl_ff),
		.q_o(req_tgl_sync)
	);

	// The acknowledge toggle returns to the system clock through its own pair.
	bit_sync u_ack_sync (
		.clk_i(clk_sys_i),
		.d_i(ack_tgl_ff),
		.q_o(ack_tgl_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: two-entry buffer ahead of the shifter.

	logic buf_in_valid;
	logic buf_in_ready;
	logic buf_out_valid;
	logic buf_out_ready;
	logic [WORD_BITS-1:0] buf_out_data;

	// A new request toggle offers the held word to the buffer.
	assign buf_in_valid = (req_tgl_sync != ack_tgl_ff);

	// Acknowledge only once the buffer took the word, so a stall loses nothing.
	always_ff @(posedge clk_link_i) begin
		if (rst_link) begin
			ack_tgl_ff <= 1'b0;
		end else if (buf_in_valid && buf_in_ready) begin
			ack_tgl_ff <= req_tgl_sync;
		end
	end

	// Two entries let the crossing run ahead while the shifter is busy.
	word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(LINK_BUF_DEPTH)
	) u_link_buf (
		.clk_i(clk_link_i),
		.srst_i(rst_link),
		.in_valid_i(buf_in_valid),
		.in_ready_o(buf_in_ready),
		.in_data_i(hold_word_ff),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_out_ready),
		.out_data_o(buf_out_data),
		.count_o()
	);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: nibble shifter and raster sequencing.

	typedef enum logic [1:0] {
		SH_LOAD,
		SH_DATA,
		SH_CLOCK,
		SH_LATCH
	} shift_state_t;

	shift_state_t shift_state_ff;
	logic [WORD_BITS-1:0] word_ff;
	logic [NIB_IDX_W-1:0] nib_ff;
	logic [COL_IDX_W-1:0] col_ff;
	logic [ROW_IDX_W-1:0] row_ff;
	logic started_ff;

	// The shifter pulls a word only while it is empty.
	assign buf_out_ready = (shift_state_ff == SH_LOAD);

	// Nibble sequencer: data phase, clock phase, latch after a full line.
	always_ff @(posedge clk_link_i) begin
		if (rst_link) begin
			shift_state_ff <= SH_LOAD;
			word_ff <= '0;
			nib_ff <= '0;
		end else begin
			unique case (shift_state_ff)
				SH_LOAD: begin
					if (buf_out_valid) begin
						word_ff <= buf_out_data;
						nib_ff <= '0;
						shift_state_ff <= SH_DATA;
					end
				end
				SH_DATA: begin
					shift_state_ff <= SH_CLOCK;
				end
				SH_CLOCK: begin
					word_ff <= {word_ff[WORD_BITS-NIBBLE_BITS-1:0], {NIBBLE_BITS{1'b0}}};
					nib_ff <= nib_ff + 1'b1;
					if (col_ff == COL_IDX_W'(NIBBLES_PER_LINE - 1)) begin
						shift_state_ff <= SH_LATCH;
					end else if (nib_ff == NIB_IDX_W'(NIBBLES_PER_WORD - 1)) begin
						shift_state_ff <= SH_LOAD;
					end else begin
						shift_state_ff <= SH_DATA;
					end
				end
				SH_LATCH: begin
					shift_state_ff <= SH_LOAD;
				end
			endcase
		end
	end

	// Column and row position within the fixed raster.
	always_ff @(posedge clk_link_i) begin
		if (rst_link) begin
			col_ff <= '0;
			row_ff <= '0;
		end else if (shift_state_ff == SH_CLOCK) begin
			col_ff <= col_ff + 1'b1;
		end else if (shift_state_ff == SH_LATCH) begin
			row_ff <= row_ff + 1'b1;
		end
	end

	// Driver pin registers.
	always_ff @(posedge clk_link_i) begin
		if (rst_link) begin
			lcd_pins_o <= '0;
		end else begin
			lcd_pins_o.column_shift_clock <= 1'b0;
			lcd_pins_o.line_latch_pulse <= 1'b0;
			lcd_pins_o.row_shift_clock <= 1'b0;
			lcd_pins_o.row_scan_start <= 1'b0;
			unique case (shift_state_ff)
				SH_LOAD: begin
				end
				SH_DATA: begin
					// Top nibble first puts the word's MSB at the leftmost pixel.
					lcd_pins_o.column_nibble_out <= word_ff[WORD_BITS-1 -: NIBBLE_BITS];
				end
				SH_CLOCK: begin
					lcd_pins_o.column_shift_clock <= 1'b1;
				end
				SH_LATCH: begin
					lcd_pins_o.line_latch_pulse <= 1'b1;
					lcd_pins_o.row_shift_clock <= 1'b1;
					lcd_pins_o.row_scan_start <= (row_ff == '0);
					if (row_ff == ROW_IDX_W'(FRAME_LINES - 1)) begin
						lcd_pins_o.frame_signal <= !lcd_pins_o.frame_signal;
					end
				end
			endcase
		end
	end

	// Underrun: a word was due, at any point after the first nibble (line starts included), but the buffer was empty.
	always_ff @(posedge clk_link_i) begin
		if (rst_link) begin
			started_ff <= 1'b0;
			underrun_o <= 1'b0;
		end else begin
			if (shift_state_ff == SH_DATA) begin
				started_ff <= 1'b1;
			end
			if (started_ff && shift_state_ff == SH_LOAD && !buf_out_valid) begin
				underrun_o <= 1'b1;
			end
		end
	end

endmodule

// file: tb/lcd_refresh_controller_chk.sv
// Concurrent checks on the ports of the LCD refresh controller.
`timescale 1ns/1ps
module lcd_refresh_controller_chk (
	// System side.
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire lcd_refresh_pkg::lpb_cmd_t lpb_cmd_o,
	input wire logic lpb_gnt_i,
	input wire logic lpb_rvalid_i,
	input wire logic [31:0] lpb_rdata_i,
	// Link side.
	input wire logic clk_link_i,
	input wire lcd_refresh_pkg::lcd_pins_t lcd_pins_o,
	input wire logic underrun_o
);
	import lcd_refresh_pkg::*;
	logic [5:0] nib_cnt_ff;
	////////////////////////////////////////////////////////////////////////////////
	// Counts column clocks since the last latch, so the line length can be checked.
	always_ff @(posedge clk_link_i) begin
		if (srst_i || lcd_pins_o.line_latch_pulse) begin
			nib_cnt_ff <= 6'h00;
		end else if (lcd_pins_o.column_shift_clock) begin
			nib_cnt_ff <= nib_cnt_ff + 6'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_burst;
		@(posedge clk_sys_i) disable iff (srst_i) lpb_cmd_o.req |-> lpb_cmd_o.burst_len == 2'h2;
	endproperty
	a_burst: assert property (p_burst) else $error("burst length is not two");
	property p_req_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
		lpb_cmd_o.req && !lpb_gnt_i |=> lpb_cmd_o.req && $stable(lpb_cmd_o.addr);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request moved before grant");
	property p_req_drop;
		@(posedge clk_sys_i) disable iff (srst_i) lpb_cmd_o.req && lpb_gnt_i |=> !lpb_cmd_o.req;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("request held after grant");
	property p_sclk_pulse;
		@(posedge clk_link_i) disable iff (srst_i) lcd_pins_o.column_shift_clock |=> !lcd_pins_o.column_shift_clock;
	endproperty
	a_sclk_pulse: assert property (p_sclk_pulse) else $error("column clock longer than one cycle");
	property p_sclk_data;
		@(posedge clk_link_i) disable iff (srst_i)
		lcd_pins_o.column_shift_clock |-> $stable(lcd_pins_o.column_nibble_out);
	endproperty
	a_sclk_data: assert property (p_sclk_data) else $error("nibble changed with column clock");
	property p_latch_row;
		@(posedge clk_link_i) disable iff (srst_i)
		lcd_pins_o.line_latch_pulse |-> lcd_pins_o.row_shift_clock && !lcd_pins_o.column_shift_clock;
	endproperty
	a_latch_row: assert property (p_latch_row) else $error("latch without row clock");
	property p_scan;
		@(posedge clk_link_i) disable iff (srst_i) lcd_pins_o.row_scan_start |-> lcd_pins_o.line_latch_pulse;
	endproperty
	a_scan: assert property (p_scan) else $error("scan start outside a latch");
	property p_frame;
		@(posedge clk_link_i) disable iff (srst_i) $changed(lcd_pins_o.frame_signal) |-> lcd_pins_o.line_latch_pulse;
	endproperty
	a_frame: assert property (p_frame) else $error("frame signal moved outside a latch");
	property p_line_len;
		@(posedge clk_link_i) disable iff (srst_i) lcd_pins_o.line_latch_pulse |-> nib_cnt_ff == 6'h20;
	endproperty
	a_line_len: assert property (p_line_len) else $error("line is not 32 nibbles");
	property p_underrun_sticky;
		@(posedge clk_link_i) disable iff (srst_i) underrun_o |=> underrun_o;
	endproperty
	a_underrun_sticky: assert property (p_underrun_sticky) else $error("underrun flag cleared without reset");
endmodule

// file: tb/lcd_driver_model.sv
// Behavioural column and row driver pair that rebuilds each latched line.
`timescale 1ns/1ps
module lcd_driver_model (
	// Link pins.
	input wire logic clk_link_i,
	input wire lcd_refresh_pkg::lcd_pins_t pins_i,
	// Observed results.
	output logic [127:0] line_o,
	output int lines_o,
	output int scans_o
);
	import lcd_refresh_pkg::*;
	logic [127:0] shift_ff = 128'h0;
	logic [127:0] line_ff = 128'h0;
	int lines_ff = 0;
	int scans_ff = 0;
	// Each result has a single driver: the latch process below.
	assign line_o = line_ff;
	assign lines_o = lines_ff;
	assign scans_o = scans_ff;
	// Column drivers shift a nibble per clock; the latch moves the line to the glass.
	always @(posedge clk_link_i) begin
		if (pins_i.column_shift_clock) begin
			shift_ff <= {shift_ff[123:0], pins_i.column_nibble_out};
		end
		if (pins_i.line_latch_pulse) begin
			line_ff <= shift_ff;
			lines_ff <= lines_ff + 1;
			scans_ff <= scans_ff + (pins_i.row_scan_start ? 1 : 0);
		end
	end
endmodule

// file: tb/lcd_refresh_controller_tb.sv
// Self-checking bench of the LCD refresh controller.
`timescale 1ns/1ps
module lcd_refresh_controller_tb;
	import lcd_refresh_pkg::*;
	typedef struct packed {
		logic [127:0] words;
		logic [127:0] line;
	} row_t;
	logic clk_sys_i = 1'b0;
	logic clk_link_i = 1'b0;
	logic srst_i = 1'b1;
	logic lpb_gnt_i = 1'b0;
	logic lpb_rvalid_i = 1'b0;
	logic [31:0] lpb_rdata_i = 32'h0000_0000;
	lpb_cmd_t lpb_cmd_o;
	lcd_pins_t lcd_pins_o;
	logic underrun_o;
	logic [127:0] model_line;
	int model_lines;
	int model_scans;
	logic [31:0] mem [512];
	logic [8:0] bidx;
	logic [8:0] exp_idx;
	int bcnt;
	int lat = 2;
	int blat = 2;
	int base;
	int sbase;
	int err_count = 0;
	int comparisons = 0;
	row_t rows [2] = '{
		'{128'h8000_0001_0000_0000_0000_0000_0000_0000, 128'h8000_0001_0000_0000_0000_0000_0000_0000},
		'{128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210}};
	lcd_refresh_controller DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .lpb_cmd_o(lpb_cmd_o),
		.lpb_gnt_i(lpb_gnt_i), .lpb_rvalid_i(lpb_rvalid_i), .lpb_rdata_i(lpb_rdata_i),
		.clk_link_i(clk_link_i), .lcd_pins_o(lcd_pins_o), .underrun_o(underrun_o));
	lcd_driver_model drv (.clk_link_i(clk_link_i), .pins_i(lcd_pins_o), .line_o(model_line),
		.lines_o(model_lines), .scans_o(model_scans));
	////////////////////////////////////////////////////////////////////////////////
	// Clocks: the link clock runs free and unrelated in phase.
	always #10 clk_sys_i = ~clk_sys_i;
	initial begin
		#7;
		forever #24 clk_link_i = ~clk_link_i;
	end
	// Arbiter stand-in: the processor side stays idle, so the rotation always grants this master.
	// The latency is latched per burst, so a change of lat never cuts a burst short.
	always @(negedge clk_sys_i) begin
		lpb_gnt_i <= (!srst_i && bcnt == 0 && lpb_cmd_o.req === 1'b1);
		lpb_rvalid_i <= (!srst_i && bcnt >= blat);
		if (srst_i) begin
			bcnt <= 0;
			exp_idx <= 9'h000;
		end else if (bcnt == 0 && lpb_cmd_o.req === 1'b1) begin
			bcnt <= 1;
			blat <= lat;
			bidx <= exp_idx;
			exp_idx <= exp_idx + 9'h002;
			chk_val("fetch address", {96'h0, 21'h0, exp_idx, 2'b00}, lpb_cmd_o.addr);
		end else if (bcnt > 0) begin
			bcnt <= (bcnt > blat) ? 0 : bcnt + 1;
		end
		if (bcnt >= blat) begin
			lpb_rdata_i <= mem[bidx + ((bcnt > blat) ? 9'h001 : 9'h000)];
		end else begin
			lpb_rdata_i <= ~lpb_rdata_i;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_val(input string what, input logic [127:0] exp, input logic [127:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cnt(input string what, input int exp, input int got);
		comparisons++;
		if (got != exp) begin
			err_count++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(negedge clk_sys_i);
		srst_i = 1'b1;
		repeat (12) @(negedge clk_sys_i);
		srst_i = 1'b0;
		base = model_lines;
		sbase = model_scans;
	endtask
	task automatic wait_lines(input int n, input int bound);
		int i;
		i = 0;
		while (model_lines < n && i < bound) begin
			@(negedge clk_sys_i);
			i++;
		end
		if (model_lines < n) begin
			err_count++;
			$display("unexpected line count: expected %0d seen %0d", n, model_lines);
			results();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, table rows, then a full frame and a starved bus.
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = {16'hC3A5 ^ i[15:0], i[15:0]};
		end
		repeat (12) @(negedge clk_sys_i);
		chk_val("pins in reset", 128'h0, lcd_pins_o);
		srst_i = 1'b0;
		chk_val("early request", 128'h0, lpb_cmd_o.req);
		@(negedge clk_sys_i);
		chk_val("first request", 128'h1, lpb_cmd_o.req);
		chk_val("burst length", 128'h2, lpb_cmd_o.burst_len);
		$display("reset test done");
		foreach (rows[k]) begin
			for (int j = 0; j < 4; j++) begin
				mem[j] = rows[k].words[127 - 32 * j -: 32];
			end
			do_reset();
			wait_lines(base + 1, 3000);
			chk_val("first line", rows[k].line, model_line);
			chk_cnt("scan starts", 1, model_scans - sbase);
			$display("row %0d done", k);
		end
		do_reset();
		wait_lines(base + 129, 30000);
		chk_val("wrapped line", {mem[0], mem[1], mem[2], mem[3]}, model_line);
		chk_cnt("frame scan starts", 2, model_scans - sbase);
		chk_val("frame signal", 128'h1, lcd_pins_o.frame_signal);
		chk_val("underrun", 128'h0, underrun_o);
		$display("frame test done");
		lat = 150;
		do_reset();
		for (int i = 0; i < 3000 && underrun_o !== 1'b1; i++) begin
			@(negedge clk_sys_i);
		end
		lat = 2;
		repeat (200) @(negedge clk_sys_i);
		chk_val("sticky underrun", 128'h1, underrun_o);
		$display("starved bus test done");
		results();
	end
endmodule
bind lcd_refresh_controller lcd_refresh_controller_chk u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
	.lpb_cmd_o(lpb_cmd_o), .lpb_gnt_i(lpb_gnt_i), .lpb_rvalid_i(lpb_rvalid_i), .lpb_rdata_i(lpb_rdata_i),
	.clk_link_i(clk_link_i), .lcd_pins_o(lcd_pins_o), .underrun_o(underrun_o));
